// ==== eep_consts.vh ====
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH

// opcode field values
`define EEP_OP_READ      2'h2
`define EEP_OP_WRITE     2'h1
`define EEP_OP_ERASE     2'h3
`define EEP_OP_MISC      2'h0

// sub-commands in the top two address-field bits under the misc opcode
`define EEP_SUB_EN       2'h3
`define EEP_SUB_BERASE   2'h2
`define EEP_SUB_BFILL    2'h1
`define EEP_SUB_DIS      2'h0

// field geometry
`define EEP_FLD_W        8
`define EEP_SUB_HI       7
`define EEP_SUB_LO       6
`define EEP_OP_LAST      5'h01
`define EEP_ADDR_LAST    5'h07
`define EEP_DATA_LAST    5'h0f
`define EEP_BIT_ZERO     5'h00

// pending programming kinds
`define EEP_K_NONE       3'h0
`define EEP_K_ERASE      3'h1
`define EEP_K_WRITE      3'h2
`define EEP_K_BERASE     3'h3
`define EEP_K_BFILL      3'h4

// erased word value
`define EEP_ERASED       16'hffff

// timing, in their own units, and the reference clock rate
`define EEP_CLK_MHZ      20
`define EEP_T_WORD_US    10000
`define EEP_T_BERASE_US  15000
`define EEP_T_BFILL_US   30000
`define EEP_T_SEL_LOW_NS 250
`define EEP_NS_PER_US    1000

`endif

// ==== eep_cmd.v ====
`timescale 1ns/1ps
`default_nettype none
`include "eep_consts.vh"

// simple synchronous fifo with count-based full and empty
module eep_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_ref_clk,
  input  wire             i_rst,
  input  wire             i_clr,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      fill;
  wire            push;
  wire            pop;

  assign o_in_ready  = (fill != DEPTH[AW:0]);
  assign o_out_valid = (fill != {(AW+1){1'b0}});
  assign o_out_data  = store[rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  // storage write has no reset, it only holds payload
  always @(posedge i_ref_clk) begin
    if (push) begin
      store[wp] <= i_in_data;
    end
  end

  // pointers and fill level; clear drops all content at once
  always @(posedge i_ref_clk) begin
    if (i_rst || i_clr) begin
      wp   <= {AW{1'b0}};
      rp   <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule // eep_fifo

// command front end of a x16 three-wire serial eeprom
module eep_cmd #(
  parameter        ADDR_W     = 8,
  parameter        WORD_W     = 16,
  parameter        FIFO_DEPTH = 16,
  parameter        FIFO_AW    = 4,
  parameter [19:0] WORD_CYC   = `EEP_T_WORD_US * `EEP_CLK_MHZ,
  parameter [19:0] BERASE_CYC = `EEP_T_BERASE_US * `EEP_CLK_MHZ,
  parameter [19:0] BFILL_CYC  = `EEP_T_BFILL_US * `EEP_CLK_MHZ
) (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_cs,
  input  wire i_sclk,
  input  wire i_serial_in,
  output reg  o_so,
  output reg  o_so_oe,
  output reg  o_busy
);
  // least select-low time, rounded up to whole reference cycles
  localparam integer SEL_LOW_NUM =
    (`EEP_T_SEL_LOW_NS * `EEP_CLK_MHZ + `EEP_NS_PER_US - 1) / `EEP_NS_PER_US;
  localparam [3:0] SEL_LOW_CYC = SEL_LOW_NUM[3:0];

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_OPC  = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_DATA = 6'h08;
  localparam [5:0] ST_READ = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;

  reg  [WORD_W-1:0]     mem [0:(1<<ADDR_W)-1];
  reg  [2:0]            sy1;
  reg  [2:0]            sy2;
  reg  [1:0]            sy3;
  reg  [5:0]            state;
  reg  [4:0]            cnt;
  reg  [1:0]            op;
  reg  [`EEP_FLD_W-1:0] fld;
  reg  [WORD_W-1:0]     wd;
  reg  [WORD_W-1:0]     sh;
  reg  [4:0]            rd_cnt;
  reg                   rd_pop;
  reg  [2:0]            kind;
  reg  [2:0]            pend;
  reg  [ADDR_W-1:0]     wa;
  reg  [ADDR_W-1:0]     pf_addr;
  reg                   pf_on;
  reg                   prog_en;
  reg                   stat_on;
  reg  [3:0]            low_cnt;
  reg  [19:0]           tmr;
  reg                   walk;
  reg  [2:0]            ekind;
  reg  [ADDR_W-1:0]     idx;
  wire                  cs;
  wire                  si;
  wire                  cs_rise;
  wire                  cs_fall;
  wire                  clk_rise;
  wire [`EEP_FLD_W-1:0] nfld;
  wire                  go;
  wire                  mem_we;
  wire [ADDR_W-1:0]     mem_wa;
  wire [WORD_W-1:0]     mem_wd;
  wire                  f_in_ready;
  wire                  f_out_valid;
  wire [WORD_W-1:0]     f_out_data;

  // pins pass two flops; a third stage on select and clock finds edges
  always @(posedge i_ref_clk) begin
    sy1 <= {i_cs, i_sclk, i_serial_in};
    sy2 <= sy1;
    sy3 <= sy2[2:1];
  end

  assign cs       = sy2[2];
  assign si       = sy2[0];
  assign cs_rise  = cs & ~sy3[1];
  assign cs_fall  = ~cs & sy3[1];
  assign clk_rise = cs & sy2[1] & ~sy3[0];
  assign nfld     = {fld[`EEP_FLD_W-2:0], si};

  // a programming cycle starts only from a complete instruction and enabled latch
  assign go = cs_fall && (state == ST_DONE) && (pend != `EEP_K_NONE)
              && prog_en && !o_busy;

  // select-low timer, saturating; kept through the rising edge cycle
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      low_cnt <= 4'h0;
    end else if (!cs) begin
      low_cnt <= (low_cnt == 4'hf) ? low_cnt : low_cnt + 4'h1;
    end else if (sy3[1]) begin
      low_cnt <= 4'h0;
    end
  end

  // command sequencer and output pin
  always @(posedge i_ref_clk) begin
    rd_pop <= 1'b0;
    if (i_rst) begin
      state   <= ST_IDLE;
      cnt     <= `EEP_BIT_ZERO;
      op      <= `EEP_OP_MISC;
      fld     <= {`EEP_FLD_W{1'b0}};
      wd      <= {WORD_W{1'b0}};
      sh      <= {WORD_W{1'b0}};
      rd_cnt  <= `EEP_BIT_ZERO;
      kind    <= `EEP_K_NONE;
      pend    <= `EEP_K_NONE;
      wa      <= {ADDR_W{1'b0}};
      pf_addr <= {ADDR_W{1'b0}};
      pf_on   <= 1'b0;
      prog_en <= 1'b0;
      stat_on <= 1'b0;
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      // prefetch the following words while the fifo has room
      if (pf_on && f_in_ready) begin
        pf_addr <= pf_addr + 1'b1;
      end
      // status tracks the engine for as long as it is shown
      if (stat_on) begin
        o_so <= ~o_busy;
      end
      if (cs_fall) begin
        state   <= ST_IDLE;
        pend    <= `EEP_K_NONE;
        pf_on   <= 1'b0;
        stat_on <= 1'b0;
        o_so_oe <= 1'b0;
      end else if (!cs) begin
        // held in reset while deselected; the engine runs on regardless
        state   <= ST_IDLE;
        pf_on   <= 1'b0;
        o_so_oe <= 1'b0;
      end else if (cs_rise) begin
        if (o_busy && (low_cnt >= SEL_LOW_CYC)) begin
          stat_on <= 1'b1;
          o_so    <= 1'b0;
          o_so_oe <= 1'b1;
        end
      end else if (clk_rise) begin
        case (state)
          ST_IDLE: begin
            // a start bit during a running cycle is not accepted
            if (si && !o_busy) begin
              state <= ST_OPC;
              cnt   <= `EEP_BIT_ZERO;
              pend  <= `EEP_K_NONE;
            end
          end
          ST_OPC: begin
            op <= {op[0], si};
            if (cnt == `EEP_OP_LAST) begin
              state <= ST_ADDR;
              cnt   <= `EEP_BIT_ZERO;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          ST_ADDR: begin
            fld <= nfld;
            if (cnt == `EEP_ADDR_LAST) begin
              cnt <= `EEP_BIT_ZERO;
              wa  <= nfld[ADDR_W-1:0];
              case (op)
                `EEP_OP_READ: begin
                  // read ignores the latch; dummy zero goes out now
                  state   <= ST_READ;
                  pf_addr <= nfld[ADDR_W-1:0];
                  pf_on   <= 1'b1;
                  rd_cnt  <= `EEP_BIT_ZERO;
                  o_so    <= 1'b0;
                  o_so_oe <= 1'b1;
                end
                `EEP_OP_WRITE: begin
                  state <= ST_DATA;
                  kind  <= `EEP_K_WRITE;
                end
                `EEP_OP_ERASE: begin
                  state <= ST_DONE;
                  pend  <= `EEP_K_ERASE;
                end
                default: begin
                  state <= ST_DONE;
                  case (nfld[`EEP_SUB_HI:`EEP_SUB_LO])
                    `EEP_SUB_EN: begin
                      prog_en <= 1'b1;
                    end
                    `EEP_SUB_BERASE: begin
                      pend <= `EEP_K_BERASE;
                    end
                    `EEP_SUB_BFILL: begin
                      state <= ST_DATA;
                      kind  <= `EEP_K_BFILL;
                    end
                    default: begin
                      prog_en <= 1'b0;
                    end
                  endcase
                end
              endcase
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          ST_DATA: begin
            wd <= {wd[WORD_W-2:0], si};
            if (cnt == `EEP_DATA_LAST) begin
              state <= ST_DONE;
              pend  <= kind;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          ST_READ: begin
            // new word at each word boundary, then shift msb first
            if (rd_cnt == `EEP_BIT_ZERO) begin
              o_so   <= f_out_data[WORD_W-1];
              sh     <= {f_out_data[WORD_W-2:0], 1'b0};
              rd_cnt <= `EEP_DATA_LAST;
              rd_pop <= 1'b1;
            end else begin
              o_so   <= sh[WORD_W-1];
              sh     <= {sh[WORD_W-2:0], 1'b0};
              rd_cnt <= rd_cnt - 5'h01;
            end
          end
          default: begin
            state <= ST_DONE;
          end
        endcase
      end
    end
  end

  // read-ahead buffer: the prefetcher stalls whenever it is full
  eep_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_clr       (~cs),
    .i_in_valid  (pf_on),
    .o_in_ready  (f_in_ready),
    .i_in_data   (mem[pf_addr]),
    .o_out_valid (f_out_valid),
    .i_out_ready (rd_pop),
    .o_out_data  (f_out_data)
  );

  // self-timed engine; bulk operations walk one word per reference cycle
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      tmr    <= 20'h00000;
      walk   <= 1'b0;
      ekind  <= `EEP_K_NONE;
      idx    <= {ADDR_W{1'b0}};
    end else if (go) begin
      o_busy <= 1'b1;
      ekind  <= pend;
      idx    <= {ADDR_W{1'b0}};
      walk   <= (pend == `EEP_K_BERASE) || (pend == `EEP_K_BFILL);
      if (pend == `EEP_K_BERASE) begin
        tmr <= BERASE_CYC - 20'h00001;
      end else if (pend == `EEP_K_BFILL) begin
        tmr <= BFILL_CYC - 20'h00001;
      end else begin
        tmr <= WORD_CYC - 20'h00001;
      end
    end else if (o_busy) begin
      if (tmr == 20'h00000) begin
        o_busy <= 1'b0;
      end else begin
        tmr <= tmr - 20'h00001;
      end
      if (walk) begin
        idx <= idx + 1'b1;
        if (idx == {ADDR_W{1'b1}}) begin
          walk <= 1'b0;
        end
      end
    end
  end

  // bulk fill lands the final word directly, the erase pass is implied
  assign mem_we = (go && ((pend == `EEP_K_ERASE) || (pend == `EEP_K_WRITE))) || walk;
  assign mem_wa = walk ? idx : wa;
  assign mem_wd = (walk ? (ekind == `EEP_K_BERASE) : (pend == `EEP_K_ERASE))
                  ? `EEP_ERASED : wd;

  // array has no reset: its content is the stored data
  always @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule // eep_cmd
`default_nettype wire

// ==== eep_cmd_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// pin-level checks of the eeprom front end
module eep_cmd_sva #(
  parameter [19:0] WORD_CYC   = 20'h00190,
  parameter [19:0] BERASE_CYC = 20'h00258,
  parameter [19:0] BFILL_CYC  = 20'h003e8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_busy
);
  logic [19:0] busy_cnt;
  logic        start_seen;
  // busy length; still holds the total on the cycle after busy drops
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_busy) busy_cnt <= 20'h00000;
    else busy_cnt <= busy_cnt + 20'h00001;
  end
  // a start condition seen at the pins during the current selection
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_cs) start_seen <= 1'b0;
    else if ($rose(i_sclk) && i_serial_in) start_seen <= 1'b1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_rst_quiet: assert property (disable iff (1'b0) i_rst |=> !o_so_oe && !o_busy)
    else $error("outputs active after reset");
  chk_cs_fall_hiz: assert property ($fell(i_cs) |-> ##[0:6] !o_so_oe)
    else $error("output still driven after select fell");
  chk_idle_hiz: assert property ((!i_cs)[*6] |-> !o_so_oe)
    else $error("output driven while deselected");
  chk_oe_needs_cs: assert property ($rose(o_so_oe) |-> i_cs && $past(i_cs))
    else $error("output enabled without select");
  chk_status_busy: assert property (o_so_oe && $past(o_so_oe) && $past(o_busy) && $past(o_busy, 2) |-> !o_so)
    else $error("status high while programming");
  chk_busy_start: assert property ($rose(o_busy) |-> !i_cs && !$past(i_cs))
    else $error("cycle began with select high");
  chk_busy_len: assert property ($fell(o_busy) |->
    busy_cnt == WORD_CYC || busy_cnt == BERASE_CYC || busy_cnt == BFILL_CYC)
    else $error("programming cycle length wrong");
  chk_cycle_cap: assert property (busy_cnt <= BFILL_CYC)
    else $error("programming cycle overran");
  chk_so_steady: assert property ((!i_sclk)[*2] ##1 (!i_sclk && o_so_oe && $past(o_so_oe)
    && !o_busy && !$past(o_busy) && !$past(o_busy, 2)) |-> $stable(o_so))
    else $error("data moved without a clock rise");
  // a read only drives the pin after a start condition in this selection
  chk_read_start: assert property ($rose(o_so_oe) && !$past(o_busy) |-> start_seen)
    else $error("read data without a start bit");
endmodule // eep_cmd_sva
bind eep_cmd eep_cmd_sva #(.WORD_CYC(WORD_CYC), .BERASE_CYC(BERASE_CYC), .BFILL_CYC(BFILL_CYC)) i_chk (
  .i_ref_clk, .i_rst, .i_cs, .i_sclk, .i_serial_in, .o_so, .o_so_oe, .o_busy);
`default_nettype wire

// ==== eep_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host controller model; serial clock stands low outside frames
module eep_host (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  input  wire logic i_busy,
  output var  logic o_cs,
  output var  logic o_sclk,
  output var  logic o_si
);
  logic        line;
  logic [16:0] word;
  event        got;
  // pull-up on the data out line, as a status read after completion needs
  assign line = i_so_oe ? i_so : 1'b1;
  initial begin
    o_cs = 1'b0;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  // one 400 ns clock; data set 200 ns ahead of the rise, line read before it
  task automatic shift_bit(input logic b, output logic q);
    o_si = b;
    repeat (4) @(negedge i_ref_clk);
    q = line;
    o_sclk = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    o_sclk = 1'b0;
  endtask
  // whole instruction msb first, then nw words read out; select drops with the last fall
  task automatic frame(input int n, input logic [26:0] v, input int nw);
    logic q;
    logic d;
    logic [15:0] acc;
    o_cs = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    for (int i = n - 1; i >= 0; i--) shift_bit(v[i], q);
    if (nw > 0) shift_bit(1'b0, d);
    for (int w = 0; w < nw; w++) begin
      for (int b = 0; b < 16; b++) begin
        shift_bit(1'b0, q);
        acc = {acc[14:0], q};
      end
      word = {d, acc};
      ->got;
    end
    o_cs = 1'b0;
    repeat (6) @(negedge i_ref_clk);
  endtask
  // reselect after 300 ns low: status before and after the cycle ends
  task automatic poll(output logic a, output logic b);
    o_cs = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    a = line;
    for (int i = 0; i < 2000 && i_busy; i++) @(negedge i_ref_clk);
    repeat (8) @(negedge i_ref_clk);
    b = line;
    o_cs = 1'b0;
    repeat (6) @(negedge i_ref_clk);
  endtask
endmodule // eep_host
`default_nettype wire

// ==== test_eep_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eep_consts.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module test_eep_cmd;
  logic        i_ref_clk, i_rst, cs, sclk, si, so, oe, busy, sa, sb;
  logic [16:0] rnd;
  logic [15:0] d1, d2, d3;
  logic [16:0] exp_q[$];
  logic [16:0] exp_w;
  int          error_cnt, cmp_count;
  eep_cmd #(.WORD_CYC(20'h00190), .BERASE_CYC(20'h00258), .BFILL_CYC(20'h003e8)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs(cs), .i_sclk(sclk), .i_serial_in(si),
    .o_so(so), .o_so_oe(oe), .o_busy(busy));
  eep_host i_host (.i_ref_clk(i_ref_clk), .i_so(so), .i_so_oe(oe), .i_busy(busy),
    .o_cs(cs), .o_sclk(sclk), .o_si(si));
  function automatic [16:0] lfsr_nx(input [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // fresh random word for write data
  task automatic next_rnd(output logic [15:0] d);
    rnd = lfsr_nx(rnd);
    d = rnd[15:0];
  endtask
  task automatic misc(input logic [1:0] sub);
    i_host.frame(11, {16'h0000, 1'b1, `EEP_OP_MISC, sub, 6'h00}, 0);
  endtask
  task automatic wr(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
    i_host.frame(27, {1'b1, op, a, d}, 0);
  endtask
  // status shows busy, then ready once the cycle is over
  task automatic stat;
    i_host.poll(sa, sb);
    `CHK(sa, 1'b0)
    `CHK(sb, 1'b1)
  endtask
  // read nw words from a; expectations noted before the traffic runs
  task automatic rd(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1, input int nw);
    exp_q.push_back({1'b0, e0});
    if (nw > 1) exp_q.push_back({1'b0, e1});
    i_host.frame(11, {16'h0000, 1'b1, `EEP_OP_READ, a}, nw);
  endtask
  // each word read is matched against the oldest note
  always @(i_host.got) begin
    // pop once, so that a mismatch report does not eat a second note
    if (exp_q.size() == 0) `CHK(i_host.word, 17'h1ffff)
    else begin
      exp_w = exp_q.pop_front();
      `CHK(i_host.word, exp_w)
    end
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    i_rst = 1'b1;
    rnd = 17'h15d10;
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    `CHK(oe, 1'b0)
    next_rnd(d1);
    wr(`EEP_OP_WRITE, 8'h05, d1);
    `CHK(busy, 1'b0)
    $display("test locked done");
    misc(`EEP_SUB_EN);
    wr(`EEP_OP_WRITE, 8'h05, d1);
    stat();
    next_rnd(d2);
    wr(`EEP_OP_WRITE, 8'h06, d2);
    stat();
    rd(8'h05, d1, d2, 2);
    i_host.frame(11, {16'h0000, 1'b1, `EEP_OP_ERASE, 8'h06}, 0);
    stat();
    rd(8'h06, `EEP_ERASED, 16'h0000, 1);
    $display("test word ops done");
    next_rnd(d3);
    wr(`EEP_OP_MISC, {`EEP_SUB_BFILL, 6'h00}, d3);
    stat();
    wr(`EEP_OP_WRITE, 8'h7f, d1);
    stat();
    rd(8'hff, d3, d3, 2);
    rd(8'h7f, d1, d3, 2);
    misc(`EEP_SUB_BERASE);
    stat();
    rd(8'h7f, `EEP_ERASED, `EEP_ERASED, 2);
    $display("test bulk ops done");
    i_host.frame(19, {8'h00, 1'b1, `EEP_OP_WRITE, 8'h7f, d2[15:8]}, 0);
    `CHK(busy, 1'b0)
    misc(`EEP_SUB_DIS);
    wr(`EEP_OP_WRITE, 8'h7f, d2);
    `CHK(busy, 1'b0)
    rd(8'h7f, `EEP_ERASED, 16'h0000, 1);
    $display("test protect done");
    `CHK(exp_q.size(), 0)
    complete_run();
  end
endmodule // test_eep_cmd
`default_nettype wire
